// ---- hdl/byte_fifo.sv ----
`timescale 1ns/100ps
module byte_fifo import mailbox_pkg::*; #(
    parameter int WIDTH = data_width,
    parameter int DEPTH = fifo_depth
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    input wire logic flush,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0] count;
        logic in_ready;
        logic out_valid;
    } fifo_state_t;

    fifo_state_t q, d;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push, pop;

    assign push = in_valid & q.in_ready;
    assign pop = out_ready & q.out_valid;
    assign in_ready = q.in_ready;
    assign out_valid = q.out_valid;
    assign out_data = mem[q.rd_ptr];

    // pointer and flag update; flags are flops so both readies are honest
    always_comb begin
        d = q;
        if (push) d.wr_ptr = (q.wr_ptr == AW'(DEPTH - 1)) ? '0 : q.wr_ptr + AW'(1);
        if (pop) d.rd_ptr = (q.rd_ptr == AW'(DEPTH - 1)) ? '0 : q.rd_ptr + AW'(1);
        d.count = q.count + (AW+1)'(push) - (AW+1)'(pop);
        if (flush) begin
            d.wr_ptr = '0;
            d.rd_ptr = '0;
            d.count = '0;
        end
        d.in_ready = (d.count != (AW+1)'(DEPTH));
        d.out_valid = (d.count != '0);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q <= '{wr_ptr: '0, rd_ptr: '0, count: '0, in_ready: 1'b1, out_valid: 1'b0};
        end else begin
            q <= d;
        end
    end

    // storage has no reset; contents are only read once valid
    always_ff @(posedge clk) begin
        if (push && !flush) begin
            mem[q.wr_ptr] <= in_data;
        end
    end

endmodule // byte_fifo

// ---- hdl/host_peer_byte_mailbox.sv ----
// Functional notes
// - status read returns ones in bits 7 and 6
// - liveness, stall, direction and reset bits read low when true
// - peer data port access stalls peer until host complements it
// - control write with bit 4 set holds peer in reset
// - control write with bit 1 set raises inbound flag unless bit 4 is also set
// - outbound flag visible in status and drives host request line
// - host data read delivers peer byte and releases peer
// - host checks read stall, its data write releases peer with byte
// - any write to acknowledge port clears outbound flag unless the peer sets it in the same cycle
// - outbound flag reads zero while a message is pending
// - direction bit zero while stalled writing, one while reading
// - inbound flag readable by host in status view
// - first byte of long messages should carry the length
// - host offsets: 0 status/control, 1 data, 2 liveness/flag clear
// - peer decode 2x outbound set, 3x inbound clear, 6x live, 7x data
// - peer held in reset after power-up until host clears bit 4
`timescale 1ns/100ps
module host_peer_byte_mailbox import mailbox_pkg::*; #(
    parameter int DEPTH = fifo_depth
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // host i/o port, strobes one cycle wide
    input wire logic host_sel,
    input wire logic [1:0] host_addr,
    input wire logic host_rd,
    input wire logic host_wr,
    input wire logic [7:0] host_wdata,
    output logic [7:0] host_rdata,
    output logic host_wr_ready,
    output logic host_irq_n,
    // peer cpu local i/o port
    input wire logic [7:0] peer_addr,
    input wire logic peer_rd,
    input wire logic peer_wr,
    input wire logic [7:0] peer_wdata,
    output logic [7:0] peer_rdata,
    output logic peer_ack,
    output logic peer_wait,
    output logic peer_reset_n
);

    // ---------------------------------------------------------------
    // state and decode helpers
    // ---------------------------------------------------------------
    typedef struct packed {
        peer_state_t pst;
        logic stall;
        logic held;
        logic out_flag;
        logic in_flag;
        logic liveness_n;
        logic [7:0] p2h_byte;
        logic [7:0] host_rdata;
        logic [7:0] peer_rdata;
        logic peer_ack;
        logic irq_n;
    } state_t;

    state_t q, d;

    // status byte seen by host and by the peer's own status port
    function automatic logic [7:0] status_byte(input state_t s);
        logic [7:0] b;
        b = 8'h00;
        b[7:6] = status_unused_val;
        b[outbound_bit_pos] = ~s.out_flag;
        b[inbound_bit_pos] = s.in_flag;
        b[liveness_bit_pos] = ~s.liveness_n;
        b[stall_bit_pos] = ~s.stall;
        b[reset_bit_pos] = ~s.held;
        b[direction_bit_pos] = (s.pst != peer_hold_wr);
        return b;
    endfunction

    // peer port range from the upper address nibble
    function automatic logic peer_hit(input logic [7:0] a, input logic [3:0] port);
        return a[7:4] == port;
    endfunction

    // ---------------------------------------------------------------
    // host to peer buffer
    // ---------------------------------------------------------------
    logic h_rd, h_wr, h_data_push;
    logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
    logic [7:0] fifo_out_data;

    assign h_rd = host_sel & host_rd;
    assign h_wr = host_sel & host_wr;
    // bytes are refused while the peer is held in reset
    assign h_data_push = h_wr & (host_addr == host_data_port) & ~q.held;
    assign fifo_out_ready = ~q.held & (q.pst == peer_hold_rd);

    byte_fifo #(
        .WIDTH(data_width),
        .DEPTH(DEPTH)
    ) u_h2p_fifo (
        .clk(clk),
        .rst_b(rst_b),
        .flush(q.held),
        .in_valid(h_data_push),
        .in_ready(fifo_in_ready),
        .in_data(host_wdata),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    // clears are applied before sets so a same-cycle set wins, except that holding the peer clears all flags last
    always_comb begin
        d = q;
        d.peer_ack = 1'b0;
        if (h_rd) begin
            unique case (host_addr)
                host_status_port: begin
                    d.host_rdata = status_byte(q);
                end
                host_data_port: begin
                    d.host_rdata = q.p2h_byte;
                    if (q.pst == peer_hold_wr) begin
                        d.pst = peer_idle;
                        d.stall = 1'b0;
                        d.peer_ack = 1'b1;
                    end
                end
                outbound_flag_ack_port: begin
                    d.host_rdata = byte_rst;
                    d.liveness_n = 1'b0;
                end
                default: d.host_rdata = byte_rst;
            endcase
        end
        if (h_wr) begin
            if (host_addr == host_status_port) d.held = host_wdata[ctrl_reset_pos];
            if (host_addr == outbound_flag_ack_port) d.out_flag = 1'b0;
        end
        if (!q.held) begin
            if (q.pst == peer_hold_rd) begin
                if (fifo_out_valid) begin
                    d.peer_rdata = fifo_out_data;
                    d.pst = peer_idle;
                    d.stall = 1'b0;
                    d.peer_ack = 1'b1;
                end
            end else if (q.pst == peer_idle && (peer_rd || peer_wr)) begin
                d.peer_rdata = byte_rst;
                d.peer_ack = 1'b1;
                if (peer_hit(peer_addr, peer_data_port)) begin
                    d.peer_ack = 1'b0;
                    d.stall = 1'b1;
                    d.pst = peer_wr ? peer_hold_wr : peer_hold_rd;
                    if (peer_wr) d.p2h_byte = peer_wdata;
                end else if (peer_rd) begin
                    if (peer_hit(peer_addr, outbound_flag_set_port)) d.out_flag = 1'b1;
                    if (peer_hit(peer_addr, inbound_flag_clr_port)) d.in_flag = 1'b0;
                    if (peer_hit(peer_addr, liveness_set_port)) d.liveness_n = 1'b1;
                    if (peer_hit(peer_addr, peer_status_port)) d.peer_rdata = status_byte(q);
                end
            end
        end
        if (h_wr && host_addr == host_status_port && host_wdata[ctrl_inbound_pos]) begin
            d.in_flag = 1'b1;
        end
        if (d.held) begin
            d.pst = peer_idle;
            d.stall = 1'b0;
            d.out_flag = 1'b0;
            d.in_flag = 1'b0;
            d.liveness_n = 1'b0;
            d.peer_ack = 1'b0;
        end
        d.irq_n = ~d.out_flag;
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    // peer held after power-up
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q <= '{pst: peer_idle, stall: 1'b0, held: held_rst, out_flag: 1'b0,
                   in_flag: 1'b0, liveness_n: 1'b0, p2h_byte: byte_rst, host_rdata: byte_rst,
                   peer_rdata: byte_rst, peer_ack: 1'b0, irq_n: 1'b1};
        end else begin
            q <= d;
        end
    end

    // outputs straight from flops; reset shown low true
    assign host_rdata = q.host_rdata;
    assign host_wr_ready = fifo_in_ready;
    assign host_irq_n = q.irq_n;
    assign peer_rdata = q.peer_rdata;
    assign peer_ack = q.peer_ack;
    assign peer_wait = q.stall;
    assign peer_reset_n = ~q.held;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    logic st_rd, data_rd, ctl_wr, peer_data_go;
    assign st_rd = h_rd && host_addr == host_status_port;
    assign data_rd = h_rd && host_addr == host_data_port;
    assign ctl_wr = h_wr && host_addr == host_status_port;
    assign peer_data_go = !q.held && q.pst == peer_idle && (peer_rd || peer_wr)
                          && peer_hit(peer_addr, peer_data_port);

    sequence s_reader_stalled;
        q.pst == peer_hold_rd && !q.held && !fifo_out_valid;
    endsequence
    sequence s_host_sends;
        h_data_push && fifo_in_ready && !(ctl_wr && host_wdata[ctrl_reset_pos]);
    endsequence

    chk_unused_bits_high: assert property (st_rd |=> host_rdata[7:6] == 2'b11)
        else $error("status bits 7:6 not one");
    chk_reset_bit_holds: assert property (ctl_wr && host_wdata[ctrl_reset_pos]
        |=> !peer_reset_n && !peer_wait)
        else $error("peer not held after reset write");
    chk_inbound_raise: assert property (ctl_wr && host_wdata[ctrl_inbound_pos]
        && !host_wdata[ctrl_reset_pos] |=> q.in_flag)
        else $error("inbound flag not raised");
    chk_peer_stall_entry: assert property (peer_data_go && !ctl_wr
        |=> peer_wait && !peer_ack)
        else $error("peer not stalled on data port");
    chk_write_release: assert property (data_rd && q.pst == peer_hold_wr && !ctl_wr
        |=> !peer_wait && peer_ack && host_rdata == $past(q.p2h_byte))
        else $error("peer write not delivered");
    chk_send_release: assert property (s_reader_stalled ##0 s_host_sends
        |-> ##[2:3] (peer_ack && peer_rdata == $past(host_wdata, 2)))
        else $error("stalled reader not released with byte");
    chk_ack_clears_flag: assert property (h_wr && host_addr == outbound_flag_ack_port
        && !(peer_rd && peer_hit(peer_addr, outbound_flag_set_port)) |=> !q.out_flag)
        else $error("outbound flag not cleared");
    chk_irq_tracks_flag: assert property (host_irq_n == !q.out_flag)
        else $error("request line disagrees with flag");
    chk_outbound_view: assert property (st_rd |=> host_rdata[outbound_bit_pos]
        == !$past(q.out_flag) && host_rdata[inbound_bit_pos] == $past(q.in_flag))
        else $error("flag view wrong");
    chk_direction_bit: assert property (st_rd |=> host_rdata[direction_bit_pos]
        == ($past(q.pst) != peer_hold_wr) && host_rdata[stall_bit_pos] == !$past(q.stall))
        else $error("direction or stall bit wrong");
    chk_reset_clears_all: assert property (!peer_reset_n
        |-> !peer_wait && !q.out_flag && !q.in_flag && !peer_ack)
        else $error("reset left state pending");

    // ---------------------------------------------------------------
    // peer side decode checks
    // ---------------------------------------------------------------
    // a peer read of a flag port only counts when the peer is free to run
    logic peer_go, rst_wr, live_clr;
    assign peer_go = !q.held && q.pst == peer_idle && peer_rd && !peer_wr;
    assign rst_wr = ctl_wr && host_wdata[ctrl_reset_pos];
    assign live_clr = h_rd && host_addr == outbound_flag_ack_port;

    sequence s_outbound_set;
        peer_go && peer_hit(peer_addr, outbound_flag_set_port) && !rst_wr;
    endsequence
    sequence s_live_set;
        peer_go && peer_hit(peer_addr, liveness_set_port) && !rst_wr;
    endsequence

    // set beats the host acknowledge, so the request line must drop at once
    chk_irq_on_set: assert property (s_outbound_set |=> !host_irq_n && q.out_flag)
        else $error("request line not raised on outbound set");
    // liveness set beats a same-cycle host clear
    chk_live_set: assert property (s_live_set |=> q.liveness_n)
        else $error("liveness not set by peer");
    chk_inbound_clear: assert property (peer_go && peer_hit(peer_addr, inbound_flag_clr_port)
        && !(ctl_wr && host_wdata[ctrl_inbound_pos]) |=> !q.in_flag)
        else $error("inbound flag not cleared by peer");
    chk_live_clear: assert property (live_clr && !(peer_go
        && peer_hit(peer_addr, liveness_set_port)) |=> !q.liveness_n)
        else $error("liveness not cleared by host read");
    chk_unused_port: assert property (h_rd && host_addr == 2'h3 |=> host_rdata == 8'hFF)
        else $error("unused host port not all ones");
    // a held peer must never see an access complete
    chk_held_no_ack: assert property (!peer_reset_n |=> !peer_ack)
        else $error("held peer acknowledged");

endmodule // host_peer_byte_mailbox

// ---- pkg/mailbox_pkg.sv ----
package mailbox_pkg;

    // ---------------------------------------------------------------
    // host port offsets from the peer's base
    // ---------------------------------------------------------------
    localparam logic [1:0] host_status_port = 2'h0;
    localparam logic [1:0] host_data_port = 2'h1;
    localparam logic [1:0] outbound_flag_ack_port = 2'h2;

    // ---------------------------------------------------------------
    // host status view bit positions (all flags except inbound read low true)
    // ---------------------------------------------------------------
    localparam int outbound_bit_pos = 0;
    localparam int inbound_bit_pos = 1;
    localparam int liveness_bit_pos = 2;
    localparam int stall_bit_pos = 3;
    localparam int reset_bit_pos = 4;
    localparam int direction_bit_pos = 5;
    localparam logic [1:0] status_unused_val = 2'h3;

    // ---------------------------------------------------------------
    // host control write bit positions
    // ---------------------------------------------------------------
    localparam int ctrl_inbound_pos = 1;
    localparam int ctrl_reset_pos = 4;

    // ---------------------------------------------------------------
    // peer port decode, upper address nibble
    // ---------------------------------------------------------------
    localparam logic [3:0] outbound_flag_set_port = 4'h2;
    localparam logic [3:0] inbound_flag_clr_port = 4'h3;
    localparam logic [3:0] peer_status_port = 4'h5;
    localparam logic [3:0] liveness_set_port = 4'h6;
    localparam logic [3:0] peer_data_port = 4'h7;

    // ---------------------------------------------------------------
    // reset values and sizes
    // ---------------------------------------------------------------
    localparam logic held_rst = 1'b1;
    localparam logic [7:0] byte_rst = 8'hFF;
    localparam int fifo_depth = 32;
    localparam int data_width = 8;

    // peer side access state
    typedef enum logic [1:0] {
        peer_idle,
        peer_hold_wr,
        peer_hold_rd
    } peer_state_t;

endpackage

// ---- tb/host_peer_byte_mailbox_bench.sv ----
`timescale 1ns/100ps
module host_peer_byte_mailbox_bench import mailbox_pkg::*;;
    localparam int depth = 4;
    logic clk;
    logic rst_b;
    logic host_sel;
    logic [1:0] host_addr;
    logic host_rd;
    logic host_wr;
    logic [7:0] host_wdata;
    logic [7:0] host_rdata;
    logic host_wr_ready;
    logic host_irq_n;
    logic [7:0] peer_addr;
    logic peer_rd;
    logic peer_wr;
    logic [7:0] peer_wdata;
    logic [7:0] peer_rdata;
    logic peer_ack;
    logic peer_wait;
    logic peer_reset_n;
    int num_errors = 0;
    int compares = 0;
    logic [7:0] d;
    logic [7:0] pd;
    logic ok;

    // small fifo depth so fill and drain stay short
    host_peer_byte_mailbox #(.DEPTH(depth)) u_host_peer_byte_mailbox (
        .clk(clk), .rst_b(rst_b), .host_sel(host_sel), .host_addr(host_addr),
        .host_rd(host_rd), .host_wr(host_wr), .host_wdata(host_wdata),
        .host_rdata(host_rdata), .host_wr_ready(host_wr_ready), .host_irq_n(host_irq_n),
        .peer_addr(peer_addr), .peer_rd(peer_rd), .peer_wr(peer_wr),
        .peer_wdata(peer_wdata), .peer_rdata(peer_rdata), .peer_ack(peer_ack),
        .peer_wait(peer_wait), .peer_reset_n(peer_reset_n));

    peer_cpu_model u_peer_cpu_model (
        .clk(clk), .peer_addr(peer_addr), .peer_rd(peer_rd), .peer_wr(peer_wr),
        .peer_wdata(peer_wdata), .peer_rdata(peer_rdata), .peer_ack(peer_ack));

    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ----------------------------------------------------------------
    // host port tasks and checks
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // answer is registered, so it is picked up half a cycle after the taking edge
    task automatic host_get(input logic [1:0] a, output logic [7:0] q);
        @(posedge clk);
        host_sel <= 1'b1;
        host_rd <= 1'b1;
        host_addr <= a;
        @(posedge clk);
        host_sel <= 1'b0;
        host_rd <= 1'b0;
        @(negedge clk);
        q = host_rdata;
    endtask

    task automatic host_put(input logic [1:0] a, input logic [7:0] v);
        @(posedge clk);
        host_sel <= 1'b1;
        host_wr <= 1'b1;
        host_addr <= a;
        host_wdata <= v;
        @(posedge clk);
        host_sel <= 1'b0;
        host_wr <= 1'b0;
        host_wdata <= ~v;
    endtask

    task automatic status(input logic [7:0] exp);
        host_get(host_status_port, d);
        check("status", exp, d);
    endtask

    task automatic wait_stall;
        for (int n = 0; n < 20 && peer_wait !== 1'b1; n++) @(posedge clk);
        check("peer_wait", 8'h01, {7'h0, peer_wait});
    endtask

    task automatic summarize;
        if (num_errors == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        #100000;
        num_errors++;
        summarize();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        rst_b = 1'b0;
        host_sel = 1'b0;
        host_addr = 2'h0;
        host_rd = 1'b0;
        host_wr = 1'b0;
        host_wdata = 8'h00;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        check("host_rdata", 8'hFF, host_rdata);
        check("outs", 8'h03, {3'h0, peer_reset_n, peer_ack, peer_wait, host_irq_n,
                              host_wr_ready});
        status(8'hED);
        u_peer_cpu_model.access(1'b0, 8'h20, 8'h00, 6, pd, ok);
        check("held ack", 8'h00, {7'h0, ok});
        host_put(host_status_port, 8'h00);
        repeat (4) @(posedge clk);
        check("peer_reset_n", 8'h01, {7'h0, peer_reset_n});
        status(8'hFD);
        u_peer_cpu_model.access(1'b0, 8'h55, 8'h00, 6, pd, ok);
        check("peer status", 8'hFD, pd);
        // liveness set by peer, cleared by host read of offset 2
        u_peer_cpu_model.access(1'b0, 8'h6C, 8'h00, 6, pd, ok);
        status(8'hF9);
        host_get(outbound_flag_ack_port, d);
        status(8'hFD);
        host_get(2'h3, d);
        check("unused port", 8'hFF, d);
        // peer to host: flag first, then one byte
        u_peer_cpu_model.access(1'b0, 8'h2A, 8'h00, 6, pd, ok);
        status(8'hFC);
        check("irq_n", 8'h00, {7'h0, host_irq_n});
        host_put(outbound_flag_ack_port, 8'h5A);
        status(8'hFD);
        check("irq_n", 8'h01, {7'h0, host_irq_n});
        fork
            u_peer_cpu_model.access(1'b1, 8'h7F, 8'hA5, 40, pd, ok);
            begin
                wait_stall();
                status(8'hD5);
                host_get(host_data_port, d);
                check("p2h byte", 8'hA5, d);
            end
        join
        check("p2h ack", 8'h01, {7'h0, ok});
        // host to peer: inbound flag, peer clears it, then reads
        host_put(host_status_port, 8'h02);
        status(8'hFF);
        u_peer_cpu_model.access(1'b0, 8'h35, 8'h00, 6, pd, ok);
        status(8'hFD);
        fork
            u_peer_cpu_model.access(1'b0, 8'h70, 8'h00, 40, pd, ok);
            begin
                wait_stall();
                status(8'hF5);
                host_put(host_data_port, 8'h3C);
            end
        join
        check("h2p byte", 8'h3C, pd);
        // fill the buffer until it refuses, then drain it with the peer
        for (int i = 0; i < depth; i++) host_put(host_data_port, 8'(8'h40 + i));
        repeat (2) @(posedge clk);
        check("wr_ready full", 8'h00, {7'h0, host_wr_ready});
        host_put(host_data_port, 8'hEE);
        for (int i = 0; i < depth; i++) begin
            u_peer_cpu_model.access(1'b0, 8'h70, 8'h00, 10, pd, ok);
            check("fifo byte", 8'(8'h40 + i), pd);
        end
        check("wr_ready empty", 8'h01, {7'h0, host_wr_ready});
        fork
            u_peer_cpu_model.access(1'b0, 8'h71, 8'h00, 40, pd, ok);
            begin
                wait_stall();
                host_put(host_data_port, 8'h77);
            end
        join
        check("after drop", 8'h77, pd);
        // reset in mid stall with both flags up
        u_peer_cpu_model.access(1'b0, 8'h20, 8'h00, 6, pd, ok);
        host_put(host_status_port, 8'h02);
        fork
            u_peer_cpu_model.access(1'b1, 8'h70, 8'hC3, 30, pd, ok);
            begin
                wait_stall();
                host_put(host_status_port, 8'h10);
                repeat (2) @(posedge clk);
                check("held outs", 8'h01, {5'h0, peer_reset_n, peer_wait, host_irq_n});
                status(8'hED);
            end
        join
        check("aborted ack", 8'h00, {7'h0, ok});
        host_put(host_status_port, 8'h00);
        repeat (4) @(posedge clk);
        status(8'hFD);
        summarize();
    end
endmodule // host_peer_byte_mailbox_bench

// ---- tb/peer_cpu_model.sv ----
`timescale 1ns/100ps
// peer cpu stand-in: one access at a time, strobe pulse, bounded wait on ack
module peer_cpu_model (
    // clock
    input wire logic clk,
    // peer local port
    output logic [7:0] peer_addr,
    output logic peer_rd,
    output logic peer_wr,
    output logic [7:0] peer_wdata,
    input wire logic [7:0] peer_rdata,
    input wire logic peer_ack
);
    // quiet port at time zero
    initial begin
        peer_addr = 8'h10;
        peer_rd = 1'b0;
        peer_wr = 1'b0;
        peer_wdata = 8'h00;
    end

    // write or read posted before host side answers
    // limit keeps a peer caught by a mid-stall reset from hanging the run
    task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata,
                          input int limit, output logic [7:0] rdata, output logic acked);
        acked = 1'b0;
        rdata = 8'h00;
        @(posedge clk);
        peer_addr <= addr;
        peer_wdata <= wdata;
        peer_rd <= !wr;
        peer_wr <= wr;
        @(posedge clk);
        peer_rd <= 1'b0;
        peer_wr <= 1'b0;
        for (int n = 0; n < limit && !acked; n++) begin
            @(posedge clk);
            if (peer_ack === 1'b1) begin
                acked = 1'b1;
                rdata = peer_rdata;
            end
        end
        // released data line shows the inverse, never a stale byte
        peer_wdata <= ~wdata;
    endtask
endmodule // peer_cpu_model
